/* core/fpsr_consts.svh */
`ifndef FPSR_CONSTS_SVH
`define FPSR_CONSTS_SVH

// Clock rate and current-sense sample lead before gate turn-off
`define FPSR_CLK_MHZ     125
`define FPSR_LEAD_NS     200
`define FPSR_LEAD_CYC    ((`FPSR_LEAD_NS * `FPSR_CLK_MHZ) / 1000)

// History buffer of current-sense samples, power of two so the index wraps
`define FPSR_HIST_AW     5
`define FPSR_HIST_DEPTH  32

// Fraction bits of every ratio and weight input
`define FPSR_Q           8

// Trip level reset value, limits and compensator gain shift
`define FPSR_TRIP_RST    16'h0200
`define FPSR_TRIP_MIN    16'h0010
`define FPSR_TRIP_MAX    16'hFF00
`define FPSR_COMP_SHIFT  4

`endif

/* core/fpsr_pkg.sv */
package fpsr_pkg;

	// Regulation scheme picked on a loop update
	typedef enum logic [1:0] {sch_cc, sch_cv, sch_lp, sch_none} fpsr_scheme_t;

	// Per-cycle calculation sequence
	typedef enum logic [1:0] {st_idle, st_meas, st_sel, st_upd} fpsr_state_t;

endpackage

/* core/fpsr_core.sv */
`timescale 1ns/10ps
`include "fpsr_consts.svh"
// Overview of operation
// [R1] Loop output sets the trip level compared at the primary current-sense pin.
// [R2] Current-sense value is taken a fixed lead time before gate turn-off.
// [R3] Peak current from sense value, sense resistance, delay and offset timing.
// [R4] Peak current feeds output current and a peak-current protection check.
// [R5] Reflected voltage is sampled at the end of demagnetization.
// [R6] Output voltage from reflected voltage, divider, turns ratio and offset.
// [R7] Output voltage feeds voltage and power loops and over/undervoltage checks.
// [R8] Clamp current is taken at the end of each gate on-time.
// [R9] Bus voltage computed from clamp current, clamp voltage, divider, turns ratio.
// [R10] Computed bus voltage is checked against the bus-sense measurement.
// [R11] Output current from peak current, turns, coupling and demag over period.
// [R12] Output current feeds current and power loops and overcurrent check.
// [R13] Each loop update picks a scheme from distances to the three setpoints.
// [R14] Current setpoint is full current weighted by derating and dimming.
// [R15] Voltage error is setpoint minus sensed output voltage.
// [R16] Power scheme caps current at power limit over output voltage.
// [R17] With any setpoint exceeded, the largest decreasing error is chosen.
// [R18] Below all setpoints, the smallest increasing error is chosen.
// [R19] Chosen error drives a compensator setting the switch drive.
// [R20] Dimming places current setpoint between minimum and full by duty.
// [R21] Power limit above voltage times full current disables the power scheme.
// [R22] Voltage setpoint at overvoltage threshold disables the voltage scheme.
// [R23] Full current at overcurrent threshold disables the current scheme.
// [R24] Ratios, offsets and setpoints are loaded before the loop runs.
module fpsr_core (
	// Clock and reset
	input  wire logic                 i_mclk,
	input  wire logic                 i_rst,
	// Configuration, captured on i_cfg_load
	input  wire logic                 i_cfg_load,
	input  wire logic [15:0]          i_cfg_pdc,
	input  wire logic [15:0]          i_cfg_cs_off,
	input  wire logic [15:0]          i_cfg_inv_rcs,
	input  wire logic [15:0]          i_cfg_div,
	input  wire logic [15:0]          i_cfg_ns_na,
	input  wire logic [15:0]          i_cfg_vout_off,
	input  wire logic [15:0]          i_cfg_r1,
	input  wire logic [15:0]          i_cfg_inv_r2,
	input  wire logic [15:0]          i_cfg_vclamp,
	input  wire logic [15:0]          i_cfg_np_na,
	input  wire logic [15:0]          i_cfg_np_ns,
	input  wire logic [15:0]          i_cfg_kcoup,
	input  wire logic [15:0]          i_cfg_vset,
	input  wire logic [15:0]          i_cfg_pset,
	input  wire logic [15:0]          i_cfg_ifull,
	input  wire logic [15:0]          i_cfg_imin,
	input  wire logic [15:0]          i_cfg_ov,
	input  wire logic [15:0]          i_cfg_uv,
	input  wire logic [15:0]          i_cfg_oc,
	input  wire logic [15:0]          i_cfg_ipk_max,
	input  wire logic [15:0]          i_cfg_bus_tol,
	// Power stage timing and sampled sense values
	input  wire logic                 i_gate_on,
	input  wire logic                 i_demag_pin,
	input  wire logic [15:0]          i_cs_adc,
	input  wire logic [15:0]          i_refl_adc,
	input  wire logic [15:0]          i_clamp_adc,
	input  wire logic [15:0]          i_bus_sense,
	// Thermal and dimming weights
	input  wire logic [15:0]          i_derate,
	input  wire logic                 i_dim_en,
	input  wire logic [15:0]          i_dim_duty,
	// Loop results
	output logic [15:0]               o_trip_level,
	output logic [15:0]               o_ipk,
	output logic [15:0]               o_vout,
	output logic [15:0]               o_vbus_fb,
	output logic [15:0]               o_iout,
	output logic signed [16:0]        o_err,
	output logic                      o_err_vld,
	output fpsr_pkg::fpsr_scheme_t    o_scheme,
	output logic                      o_loop_run,
	// Protection and plausibility flags
	output logic                      o_bus_implaus,
	output logic                      o_out_ov,
	output logic                      o_out_uv,
	output logic                      o_out_oc,
	output logic                      o_ipk_over
);
	import fpsr_pkg::*;

	// Saturate a wide unsigned result to 16 bits
	function automatic logic [15:0] sat16(input logic [63:0] v);
		sat16 = (v > 64'h000000000000FFFF) ? 16'hFFFF : v[15:0];
	endfunction

	logic [15:0] pdc_ff, csoff_ff, invrcs_ff, div_ff, nsna_ff, voff_ff;
	logic [15:0] r1_ff, invr2_ff, vcl_ff, npna_ff, npns_ff, kc_ff;
	logic [15:0] vset_ff, pset_ff, ifull_ff, imin_ff, ov_ff, uv_ff, oc_ff;
	logic [15:0] ipkmax_ff, btol_ff;
	logic        cfg_ok_ff;

	// Configuration capture; loop stays idle until the first load
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			{pdc_ff, csoff_ff, invrcs_ff, div_ff, nsna_ff, voff_ff} <= '0;
			{r1_ff, invr2_ff, vcl_ff, npna_ff, npns_ff, kc_ff} <= '0;
			{vset_ff, pset_ff, ifull_ff, imin_ff, ov_ff, uv_ff, oc_ff} <= '0;
			{ipkmax_ff, btol_ff} <= '0;
			cfg_ok_ff <= 1'b0;
		end else if (i_cfg_load) begin // R24
			{pdc_ff, csoff_ff, invrcs_ff, div_ff} <= {i_cfg_pdc, i_cfg_cs_off, i_cfg_inv_rcs, i_cfg_div};
			{nsna_ff, voff_ff, r1_ff, invr2_ff} <= {i_cfg_ns_na, i_cfg_vout_off, i_cfg_r1, i_cfg_inv_r2};
			{vcl_ff, npna_ff, npns_ff, kc_ff} <= {i_cfg_vclamp, i_cfg_np_na, i_cfg_np_ns, i_cfg_kcoup};
			{vset_ff, pset_ff, ifull_ff, imin_ff} <= {i_cfg_vset, i_cfg_pset, i_cfg_ifull, i_cfg_imin};
			{ov_ff, uv_ff, oc_ff} <= {i_cfg_ov, i_cfg_uv, i_cfg_oc};
			{ipkmax_ff, btol_ff} <= {i_cfg_ipk_max, i_cfg_bus_tol};
			cfg_ok_ff <= 1'b1;
		end
	end

	// Demag comparator pin: three stages, level taken once stages 2 and 3 agree
	logic dm_s1_ff, dm_s2_ff, dm_s3_ff, dm_ff, dm_d_ff, gate_d_ff;
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			{dm_s1_ff, dm_s2_ff, dm_s3_ff, dm_ff, dm_d_ff, gate_d_ff} <= '0;
		end else begin
			dm_s1_ff  <= i_demag_pin;
			dm_s2_ff  <= dm_s1_ff;
			dm_s3_ff  <= dm_s2_ff;
			dm_ff     <= (dm_s2_ff == dm_s3_ff) ? dm_s3_ff : dm_ff;
			dm_d_ff   <= dm_ff;
			gate_d_ff <= i_gate_on;
		end
	end

	logic gate_rise, gate_fall, demag_end;
	assign gate_rise = i_gate_on & ~gate_d_ff;
	assign gate_fall = ~i_gate_on & gate_d_ff;
	assign demag_end = ~dm_ff & dm_d_ff;

	// Current-sense history; at turn-off the entry from the lead time ago is used
	logic [15:0] hist_mem [`FPSR_HIST_DEPTH];
	logic [`FPSR_HIST_AW-1:0] wp_ff, rd_idx;
	assign rd_idx = wp_ff - (`FPSR_HIST_AW)'(`FPSR_LEAD_CYC); // R2
	always_ff @(posedge i_mclk) begin
		hist_mem[wp_ff] <= i_cs_adc;
	end

	// Switching cycle timing and sample capture
	logic [15:0] ton_cnt_ff, ton_ff, dem_cnt_ff, tdem_ff, per_cnt_ff, tsw_ff;
	logic [15:0] vcs_ff, vzcd_ff, iclamp_ff;
	logic        in_dem_ff, dem_ok_ff;
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			wp_ff <= '0;
			{ton_cnt_ff, ton_ff, dem_cnt_ff, tdem_ff, per_cnt_ff, tsw_ff} <= '0;
			{vcs_ff, vzcd_ff, iclamp_ff} <= '0;
			{in_dem_ff, dem_ok_ff} <= '0;
		end else begin
			wp_ff <= wp_ff + 1'b1;
			per_cnt_ff <= gate_rise ? 16'h0001 : sat16({48'h0, per_cnt_ff} + 64'h1);
			if (gate_rise) begin
				tsw_ff     <= per_cnt_ff;
				ton_cnt_ff <= 16'h0001;
			end else if (i_gate_on) begin
				ton_cnt_ff <= sat16({48'h0, ton_cnt_ff} + 64'h1);
			end
			if (gate_rise) begin
				dem_ok_ff <= 1'b0;
			end
			if (gate_fall) begin
				ton_ff     <= ton_cnt_ff;
				vcs_ff     <= hist_mem[rd_idx]; // R2
				iclamp_ff  <= i_clamp_adc;      // R8
				dem_cnt_ff <= '0;
				in_dem_ff  <= 1'b1;
			end else if (in_dem_ff && demag_end) begin
				tdem_ff   <= dem_cnt_ff;
				vzcd_ff   <= i_refl_adc;        // R5
				in_dem_ff <= 1'b0;
				dem_ok_ff <= 1'b1;
			end else if (in_dem_ff && dm_ff) begin
				dem_cnt_ff <= sat16({48'h0, dem_cnt_ff} + 64'h1);
			end
		end
	end

	// Measurement arithmetic, evaluated from captured samples
	logic [63:0] p_ipk, p_vout, p_vbus, p_iout, p_iset, p_ilp;
	logic [16:0] ton_den;
	always_comb begin
		ton_den = {1'b0, ton_ff} - {1'b0, csoff_ff};
		if (ton_den[16] || ton_den == 17'h0) begin
			ton_den = 17'h00001;
		end
		p_ipk  = (((64'(vcs_ff) * invrcs_ff) >> `FPSR_Q) * (64'(ton_ff) + pdc_ff)) / ton_den; // R3
		p_vout = ((((64'(vzcd_ff) * div_ff) >> `FPSR_Q) * nsna_ff) >> `FPSR_Q) + voff_ff;  // R6
		p_vbus = ((64'(iclamp_ff) + ((64'(vcl_ff) * invr2_ff) >> `FPSR_Q)) * r1_ff) >> `FPSR_Q;
		p_vbus = ((p_vbus + vcl_ff) * npna_ff) >> `FPSR_Q;                                 // R9
		p_iset = i_dim_en ? 64'(imin_ff) + (((64'(ifull_ff) - imin_ff) * i_dim_duty) >> `FPSR_Q)
			: 64'(ifull_ff);                                                               // R20
		p_iset = (p_iset * i_derate) >> `FPSR_Q;                                            // R14
	end

	// Output current and power cap use registered peak current and voltage
	logic [15:0] ipk_ff, vout_ff, vbus_ff, iout_ff, iset_ff, ilp_ff;
	always_comb begin
		p_iout = ((((64'(ipk_ff) * npns_ff) >> `FPSR_Q) * kc_ff) >> `FPSR_Q) * tdem_ff;
		p_iout = (tsw_ff == 16'h0) ? 64'h0 : p_iout / (64'(tsw_ff) << 1);                  // R11
		p_ilp  = (vout_ff == 16'h0) ? 64'hFFFF : (64'(pset_ff) << `FPSR_Q) / vout_ff;      // R16
	end

	// Scheme enables and the three errors, positive asks for more power
	logic signed [16:0] e_cc, e_cv, e_lp, e_pick;
	logic               en_cc, en_cv, en_lp;
	fpsr_scheme_t       s_pick;
	assign en_lp = (64'(pset_ff) << `FPSR_Q) <= 64'(vset_ff) * ifull_ff; // R21
	assign en_cv = vset_ff < ov_ff;                                      // R22
	assign en_cc = ifull_ff < oc_ff;                                     // R23
	assign e_cc  = $signed({1'b0, iset_ff}) - $signed({1'b0, iout_ff}); // R14
	assign e_cv  = $signed({1'b0, vset_ff}) - $signed({1'b0, vout_ff}); // R15
	assign e_lp  = $signed({1'b0, ilp_ff}) - $signed({1'b0, iout_ff});  // R16

	// Lowest enabled error: most negative when a setpoint is exceeded,
	// otherwise the smallest increase, so one compare serves both cases
	always_comb begin
		e_pick = 17'sh0;
		s_pick = sch_none;
		if (en_cc) begin // R13
			e_pick = e_cc;
			s_pick = sch_cc;
		end
		if (en_cv && (s_pick == sch_none || e_cv < e_pick)) begin // R17 R18
			e_pick = e_cv;
			s_pick = sch_cv;
		end
		if (en_lp && (s_pick == sch_none || e_lp < e_pick)) begin // R17 R18
			e_pick = e_lp;
			s_pick = sch_lp;
		end
	end

	// Sequencer: one calculation pass per completed switching cycle
	fpsr_state_t st_ff;
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			st_ff <= st_idle;
		end else begin
			unique case (st_ff)
				st_idle: begin
					if (gate_rise && dem_ok_ff && cfg_ok_ff) begin
						st_ff <= st_meas;
					end
				end
				st_meas: st_ff <= st_sel;
				st_sel:  st_ff <= st_upd;
				st_upd:  st_ff <= st_idle;
			endcase
		end
	end

	// Measurement registers; current setpoint latched with them
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			{ipk_ff, vout_ff, vbus_ff, iset_ff} <= '0;
		end else if (st_ff == st_meas) begin
			ipk_ff  <= sat16(p_ipk);  // R3
			vout_ff <= sat16(p_vout); // R6
			vbus_ff <= sat16(p_vbus); // R9
			iset_ff <= sat16(p_iset); // R14
		end
	end

	// Second stage waits a cycle because it needs the fresh peak current
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			{iout_ff, ilp_ff} <= '0;
		end else if (st_ff == st_sel) begin
			iout_ff <= sat16(p_iout); // R4 R11
			ilp_ff  <= sat16(p_ilp);  // R7 R16
		end
	end

	// Error selection and protection flags, registered once per loop update with a one-cycle valid pulse
	logic [16:0] bus_diff;
	assign bus_diff = (vbus_ff > i_bus_sense) ? 17'(vbus_ff - i_bus_sense) : 17'(i_bus_sense - vbus_ff);
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_err         <= '0;
			o_err_vld     <= 1'b0;
			o_scheme      <= sch_none;
			o_bus_implaus <= 1'b0;
			o_out_ov      <= 1'b0;
			o_out_uv      <= 1'b0;
			o_out_oc      <= 1'b0;
			o_ipk_over    <= 1'b0;
		end else begin
			o_err_vld <= (st_ff == st_upd);
			if (st_ff == st_upd) begin
				o_err         <= e_pick;                   // R13
				o_scheme      <= s_pick;                   // R13
				o_bus_implaus <= bus_diff > {1'b0, btol_ff}; // R10
				o_out_ov      <= vout_ff > ov_ff;          // R7 R22
				o_out_uv      <= vout_ff < uv_ff;          // R7
				o_out_oc      <= iout_ff > oc_ff;          // R12 R23
				o_ipk_over    <= ipk_ff > ipkmax_ff;       // R4
			end
		end
	end

	// Integrating compensator on the trip level; clamped so it never winds up
	logic signed [17:0] trip_sum;
	assign trip_sum = $signed({2'b00, o_trip_level}) + (o_err >>> `FPSR_COMP_SHIFT);
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_trip_level <= `FPSR_TRIP_RST;
		end else if (o_err_vld) begin // R1 R19
			if (trip_sum < $signed({2'b00, `FPSR_TRIP_MIN})) begin
				o_trip_level <= `FPSR_TRIP_MIN;
			end else if (trip_sum > $signed({2'b00, `FPSR_TRIP_MAX})) begin
				o_trip_level <= `FPSR_TRIP_MAX;
			end else begin
				o_trip_level <= trip_sum[15:0];
			end
		end
	end

	// Result outputs copied from the measurement stage
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			{o_ipk, o_vout, o_vbus_fb, o_iout} <= '0;
			o_loop_run <= 1'b0;
		end else begin
			o_loop_run <= cfg_ok_ff; // R24
			if (st_ff == st_upd) begin
				{o_ipk, o_vout, o_vbus_fb, o_iout} <= {ipk_ff, vout_ff, vbus_ff, iout_ff};
			end
		end
	end

	// Checks on the loop's sample registers, sequencer and outputs
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);

	a_cs_lead_sample: assert property (gate_fall |=> vcs_ff == $past(i_cs_adc, `FPSR_LEAD_CYC + 1)) // R2
		else $error("current sense not taken at the lead time");
	a_clamp_at_off: assert property (gate_fall |=> iclamp_ff == $past(i_clamp_adc)) // R8
		else $error("clamp current not taken at turn-off");
	a_calc_sequence: assert property (st_ff == st_meas |=> st_ff == st_sel ##1 st_ff == st_upd ##1 o_err_vld) // R13
		else $error("calculation pass out of order");
	a_err_one_pulse: assert property (o_err_vld |=> !o_err_vld [*3]) // R13
		else $error("error strobe longer than one cycle");
	a_power_excluded: assert property (o_err_vld && !$past(en_lp) |-> o_scheme != sch_lp) // R21
		else $error("disabled power scheme chosen");
	a_volt_excluded: assert property (o_err_vld && !$past(en_cv) |-> o_scheme != sch_cv) // R22
		else $error("disabled voltage scheme chosen");
	a_curr_excluded: assert property (o_err_vld && !$past(en_cc) |-> o_scheme != sch_cc) // R23
		else $error("disabled current scheme chosen");
	a_pick_lowest: assert property (o_err_vld && $past(en_cv) |-> o_err <= $past(e_cv)) // R17 R18
		else $error("chosen error not the lowest");
	a_trip_rises: assert property (o_err_vld && o_err > 17'sh20 && o_trip_level < 16'hFE00
		|=> o_trip_level > $past(o_trip_level)) // R1 R19
		else $error("trip level did not rise on positive error");
	a_cfg_first: assert property (!cfg_ok_ff |-> st_ff == st_idle && !o_loop_run) // R24
		else $error("loop active before configuration");

	c_pick_cc: cover property (o_err_vld && o_scheme == sch_cc);
	c_pick_cv: cover property (o_err_vld && o_scheme == sch_cv);
	c_pick_lp: cover property (o_err_vld && o_scheme == sch_lp);
	c_implaus: cover property (o_err_vld && o_bus_implaus);

endmodule // fpsr_core

/* tb/fpsr_stage_model.sv */
`timescale 1ns/10ps
module fpsr_stage_model #(
	parameter int TON  = 60,
	parameter int TDEM = 40,
	parameter int TPER = 125
) (
	// Clock and reset
	input  wire logic        i_mclk,
	input  wire logic        i_rst,
	// Levels shown inside their windows
	input  wire logic [15:0] i_sense_lvl,
	input  wire logic [15:0] i_refl_lvl,
	input  wire logic [15:0] i_clamp_lvl,
	// Stage pins
	output logic             o_gate_on,
	output logic             o_demag,
	output logic [15:0]      o_cs,
	output logic [15:0]      o_refl,
	output logic [15:0]      o_clamp
);
	int cnt_ff;

	// Phase counter; reset parks it just before a gate rise
	always @(negedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			cnt_ff <= TPER - 1;
		end else begin
			cnt_ff <= (cnt_ff == TPER - 1) ? 0 : cnt_ff + 1;
		end
	end

	// Outside its window a level shows its inverse, so an early or late sample is seen
	always_comb begin
		o_gate_on = (cnt_ff < TON);
		o_demag   = (cnt_ff >= TON + 2) && (cnt_ff < TON + 2 + TDEM);
		o_cs      = (cnt_ff >= TON - 40 && cnt_ff < TON - 10) ? i_sense_lvl : ~i_sense_lvl;
		o_clamp   = (cnt_ff >= TON - 10 && cnt_ff < TON + 3) ? i_clamp_lvl : ~i_clamp_lvl;
		o_refl    = (cnt_ff >= TON + TDEM - 8 && cnt_ff < TON + TDEM + 12) ? i_refl_lvl : ~i_refl_lvl;
	end
endmodule // fpsr_stage_model

/* tb/fpsr_core_tb.sv */
`timescale 1ns/10ps
module fpsr_core_tb;
	import fpsr_pkg::*;
	logic [15:0] dly_comp, cs_off, inv_rcs, div, ns_na, vo_off, r1, inv_r2, vclamp, np_na, np_ns, kcoup;
	logic [15:0] vset, pset, ifull, imin, ov, uv, oc, ipk_max, tol, bus_meas, derate, duty, pk_sense, refl, clamp;
	logic mclk, rst, load, dim_en, gate, demag;
	logic [15:0] cs_adc, refl_adc, clamp_adc, trip, ipk, vout, vbus, iout;
	logic signed [16:0] err;
	logic err_vld, loop_run, implaus, f_ov, f_uv, f_oc, ipk_over;
	fpsr_scheme_t scheme;
	int mismatches = 0;
	int comparisons = 0;

	fpsr_stage_model i_fpsr_stage_model (.i_mclk(mclk), .i_rst(rst), .i_sense_lvl(pk_sense), .i_refl_lvl(refl),
		.i_clamp_lvl(clamp), .o_gate_on(gate), .o_demag(demag), .o_cs(cs_adc), .o_refl(refl_adc),
		.o_clamp(clamp_adc));

	fpsr_core i_fpsr_core (.i_mclk(mclk), .i_rst(rst), .i_cfg_load(load), .i_cfg_pdc(dly_comp),
		.i_cfg_cs_off(cs_off), .i_cfg_inv_rcs(inv_rcs), .i_cfg_div(div), .i_cfg_ns_na(ns_na),
		.i_cfg_vout_off(vo_off), .i_cfg_r1(r1), .i_cfg_inv_r2(inv_r2), .i_cfg_vclamp(vclamp),
		.i_cfg_np_na(np_na), .i_cfg_np_ns(np_ns), .i_cfg_kcoup(kcoup), .i_cfg_vset(vset), .i_cfg_pset(pset),
		.i_cfg_ifull(ifull), .i_cfg_imin(imin), .i_cfg_ov(ov), .i_cfg_uv(uv), .i_cfg_oc(oc),
		.i_cfg_ipk_max(ipk_max), .i_cfg_bus_tol(tol), .i_gate_on(gate), .i_demag_pin(demag),
		.i_cs_adc(cs_adc), .i_refl_adc(refl_adc), .i_clamp_adc(clamp_adc), .i_bus_sense(bus_meas),
		.i_derate(derate), .i_dim_en(dim_en), .i_dim_duty(duty), .o_trip_level(trip), .o_ipk(ipk),
		.o_vout(vout), .o_vbus_fb(vbus), .o_iout(iout), .o_err(err), .o_err_vld(err_vld), .o_scheme(scheme),
		.o_loop_run(loop_run), .o_bus_implaus(implaus), .o_out_ov(f_ov), .o_out_uv(f_uv), .o_out_oc(f_oc),
		.o_ipk_over(ipk_over));

	// 125 MHz clock
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Exact compare; four-state so an unknown never matches
	task automatic chk(input string name, input logic [16:0] exp, input logic [16:0] got);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %0h seen %0h", name, exp, got);
		end
	endtask

	// Window compare for values that carry timing quantisation
	task automatic rng(input string name, input logic [15:0] lo, input logic [15:0] hi, input logic [15:0] got);
		comparisons++;
		if ($isunknown(got) || got < lo || got > hi) begin
			mismatches++;
			$display("MISMATCH %s expected %0h..%0h seen %0h", name, lo, hi, got);
		end
	endtask

	// Bounded wait for the result pulse, looked at on the falling edge
	task automatic wait_vld();
		int n;
		n = 0;
		@(negedge mclk);
		while (err_vld !== 1'b1 && n < 400) begin
			n++;
			@(negedge mclk);
		end
		if (err_vld !== 1'b1) begin
			chk("err_vld", 17'h00001, {16'h0000, err_vld});
			wrap_up();
		end
	endtask

	// Plain setup: unity turns ratios, output 2*reflected+10, bus clamp+10, zero peak so errors are exact
	task automatic base();
		{dly_comp, cs_off, inv_rcs, div, ns_na, vo_off} = {16'h0000, 16'h0000, 16'h0200, 16'h0200, 16'h0100, 16'h000A};
		{r1, inv_r2, vclamp, np_na, np_ns, kcoup} = {16'h0100, 16'h0100, 16'h0005, 16'h0100, 16'h0100, 16'h0100};
		{vset, pset, ifull, imin, ov, uv} = {16'h03E8, 16'hFFFF, 16'h012C, 16'h0064, 16'h07D0, 16'h0000};
		{oc, ipk_max, tol, bus_meas, derate, duty} = {16'h03E8, 16'hFFFF, 16'h0014, 16'h00D2, 16'h0100, 16'h0100};
		{pk_sense, refl, clamp, dim_en, rst, load} = {16'h0000, 16'h0064, 16'h00C8, 1'b0, 1'b1, 1'b0};
	endtask

	// Reset held 3 cycles, load at the first edge after release, then the first result
	task automatic start();
		rst = 1'b1;
		repeat (3) @(negedge mclk);
		chk("trip_rst", 17'h00200, {1'b0, trip});
		chk("run_rst", 17'h00000, {16'h0000, loop_run});
		rst = 1'b0;
		load = 1'b1;
		@(negedge mclk);
		load = 1'b0;
		wait_vld();
		chk("loop_run", 17'h00001, {16'h0000, loop_run});
	endtask

	task automatic t_meas();
		base();
		pk_sense = 16'h03E8;
		oc = 16'h00C8;
		ipk_max = 16'h05DC;
		start();
		chk("ipk", 17'h007D0, {1'b0, ipk});
		chk("vout", 17'h000D2, {1'b0, vout});
		chk("vbus_fb", 17'h000D2, {1'b0, vbus});
		chk("implaus", 17'h00000, {16'h0000, implaus});
		rng("iout", 16'h0130, 16'h0150, iout);
		chk("ipk_over", 17'h00001, {16'h0000, ipk_over});
		chk("out_oc", 17'h00001, {16'h0000, f_oc});
		bus_meas = 16'h0190;
		wait_vld();
		wait_vld();
		chk("implaus", 17'h00001, {16'h0000, implaus});
		// Reload with delay compensation and sense offset: 2000*(60+15)/(60-10)
		{dly_comp, cs_off, load} = {16'h000F, 16'h000A, 1'b1};
		@(negedge mclk);
		load = 1'b0;
		wait_vld();
		chk("ipk_comp", 17'h00BB8, {1'b0, ipk});
		rng("iout_comp", 16'h01D0, 16'h01F0, iout);
		$display("test t_meas done");
	endtask

	task automatic t_cur();
		base();
		start();
		chk("scheme", {15'h0000, sch_cc}, {15'h0000, scheme});
		chk("err", 17'h0012C, err);
		@(negedge mclk);
		chk("trip", 17'h00212, {1'b0, trip});
		$display("test t_cur done");
	endtask

	task automatic t_dimming();
		base();
		{dim_en, duty, derate} = {1'b1, 16'h0080, 16'h0080};
		start();
		chk("err", 17'h00064, err);
		$display("test t_dimming done");
	endtask

	// Output above the voltage setpoint: the only power-decreasing error wins
	task automatic t_volt();
		base();
		vset = 16'h0096;
		start();
		chk("scheme", {15'h0000, sch_cv}, {15'h0000, scheme});
		chk("err", 17'h1FFC4, err);
		@(negedge mclk);
		chk("trip", 17'h001FC, {1'b0, trip});
		$display("test t_volt done");
	endtask

	task automatic t_pwr();
		base();
		{ifull, oc, pset} = {16'h03E8, 16'h07D0, 16'h01A4};
		start();
		chk("scheme", {15'h0000, sch_lp}, {15'h0000, scheme});
		chk("err", 17'h00200, err);
		$display("test t_pwr done");
	endtask

	// Voltage setpoint on the overvoltage threshold never selects the voltage error
	task automatic t_volt_off();
		base();
		{vset, ov, uv} = {16'h0096, 16'h0096, 16'h00FA};
		start();
		chk("scheme", {15'h0000, sch_cc}, {15'h0000, scheme});
		chk("err", 17'h0012C, err);
		chk("out_ov", 17'h00001, {16'h0000, f_ov});
		chk("out_uv", 17'h00001, {16'h0000, f_uv});
		$display("test t_volt_off done");
	endtask

	task automatic t_cur_off();
		base();
		oc = 16'h012C;
		start();
		chk("scheme", {15'h0000, sch_cv}, {15'h0000, scheme});
		chk("err", 17'h00316, err);
		chk("out_oc", 17'h00000, {16'h0000, f_oc});
		$display("test t_cur_off done");
	endtask

	initial begin
		base();
		t_meas();
		t_cur();
		t_dimming();
		t_volt();
		t_pwr();
		t_volt_off();
		t_cur_off();
		wrap_up();
	end
endmodule // fpsr_core_tb
